// ---- cpu_status_and_constant_regs_tb_top.sv ----
`timescale 1ns/1ps
module cpu_status_and_constant_regs_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    csr_pkg::csr_wr_t wrReq;
    csr_pkg::csr_flag_t flagReq;
    csr_pkg::csr_src_t srcReq;
    logic spPushEn, spPopEn, spAddrWord, dcoInUse, lfxtInUse, irqReq, irqTake, srcFromConst;
    logic coreHalt, dcGenHalt, loopCtrlHalt, xtalHalt, k;
    logic [19:0] srcData, stackTopPtr, v;
    logic [15:0] statusWord;
    logic [19:0] cgB [4] = '{20'h00000, 20'h00001, 20'h00002, 20'hFFFFF};
    logic [19:0] cgA [4] = '{20'h00000, 20'h00000, 20'h00004, 20'h00008};
    int error_cnt = 0;
    int compares = 0;

    always #4 clk = ~clk;

    csr_cpu_model i_cpu (.clk(clk), .srcData(srcData), .srcFromConst(srcFromConst),
        .wrReq(wrReq), .flagReq(flagReq), .srcReq(srcReq), .spPushEn(spPushEn),
        .spPopEn(spPopEn), .spAddrWord(spAddrWord), .dcoInUse(dcoInUse),
        .lfxtInUse(lfxtInUse), .irqReq(irqReq));

    csr_reg_file i_dut (.clk(clk), .rst_n(rst_n), .wrReq(wrReq), .flagReq(flagReq),
        .srcReq(srcReq), .spPushEn(spPushEn), .spPopEn(spPopEn), .spAddrWord(spAddrWord),
        .dcoInUse(dcoInUse), .lfxtInUse(lfxtInUse), .irqReq(irqReq), .irqTake(irqTake),
        .srcData(srcData), .srcFromConst(srcFromConst), .statusWord(statusWord),
        .stackTopPtr(stackTopPtr), .coreHalt(coreHalt), .dcGenHalt(dcGenHalt),
        .loopCtrlHalt(loopCtrlHalt), .xtalHalt(xtalHalt));

    task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rc(input string n, input logic [3:0] i, input logic [1:0] m,
                      input csr_pkg::csr_size_t s, input logic [19:0] e, input logic ek);
        i_cpu.rd(i, m, s, v, k);
        chk(n, v, e);
        chk({n, " const"}, 20'(k), 20'(ek));
    endtask : rc

    // halt outputs lag the status word, so allow a margin of edges
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic conclude();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        i_cpu.wr(4'h5, csr_pkg::CSR_SZ_BYTE, 1'b0, 20'hABCDE, 1'b0);
        i_cpu.wr(4'h6, csr_pkg::CSR_SZ_WORD, 1'b0, 20'hABCDE, 1'b0);
        i_cpu.wr(4'h4, csr_pkg::CSR_SZ_ADDR, 1'b0, 20'hABCDE, 1'b0);
        i_cpu.wr(4'hF, csr_pkg::CSR_SZ_ADDR, 1'b0, 20'h12345, 1'b0);
        i_cpu.wr(4'h8, csr_pkg::CSR_SZ_BYTE, 1'b1, 20'h00080, 1'b0);
        rc("r5", 4'h5, csr_pkg::MODE_REG, csr_pkg::CSR_SZ_ADDR, 20'h000DE, 1'b0);
        rc("r6", 4'h6, csr_pkg::MODE_REG, csr_pkg::CSR_SZ_ADDR, 20'h0BCDE, 1'b0);
        rc("r4", 4'h4, csr_pkg::MODE_REG, csr_pkg::CSR_SZ_ADDR, 20'hABCDE, 1'b0);
        rc("r15", 4'hF, csr_pkg::MODE_REG, csr_pkg::CSR_SZ_ADDR, 20'h12345, 1'b0);
        rc("r8", 4'h8, csr_pkg::MODE_REG, csr_pkg::CSR_SZ_ADDR, 20'hFFF80, 1'b0);
        $display("test widths done");
        i_cpu.wr(csr_pkg::REG_CG, csr_pkg::CSR_SZ_ADDR, 1'b0, 20'h55555, 1'b0);
        for (int m = 0; m < 4; m++)
            rc("cg3", csr_pkg::REG_CG, 2'(m), csr_pkg::CSR_SZ_ADDR, cgB[m], 1'b1);
        rc("cg3 b", csr_pkg::REG_CG, 2'h3, csr_pkg::CSR_SZ_BYTE, 20'h000FF, 1'b1);
        rc("cg3 w", csr_pkg::REG_CG, 2'h3, csr_pkg::CSR_SZ_WORD, 20'h0FFFF, 1'b1);
        for (int m = 1; m < 4; m++)
            rc("cg2", csr_pkg::REG_SR, 2'(m), csr_pkg::CSR_SZ_ADDR, cgA[m], 1'b1);
        $display("test constants done");
        i_cpu.wr(csr_pkg::REG_SR, csr_pkg::CSR_SZ_BYTE, 1'b0, 20'h000FF, 1'b0);
        settle();
        chk("sr byte", 20'(statusWord), 20'h00000);
        i_cpu.wr(csr_pkg::REG_SR, csr_pkg::CSR_SZ_WORD, 1'b0, 20'h0FFFF, 1'b0);
        i_cpu.env(1'b0, 1'b0, 1'b1);
        settle();
        chk("sr", 20'(statusWord), 20'h001FF);
        rc("sr reg", csr_pkg::REG_SR, csr_pkg::MODE_REG, csr_pkg::CSR_SZ_WORD, 20'h001FF, 1'b0);
        chk("halts", 20'({coreHalt, dcGenHalt, loopCtrlHalt, xtalHalt, irqTake}), 20'h0001F);
        i_cpu.env(1'b1, 1'b1, 1'b1);
        settle();
        chk("in use", 20'({dcGenHalt, xtalHalt, loopCtrlHalt}), 20'h00001);
        i_cpu.wr(csr_pkg::REG_SR, csr_pkg::CSR_SZ_WORD, 1'b0, 20'h00000, 1'b0);
        settle();
        chk("cleared", 20'({coreHalt, irqTake}), 20'h00000);
        $display("test status done");
        i_cpu.flag(csr_pkg::CSR_OP_ADD, csr_pkg::CSR_SZ_WORD, 20'h07FFF, 20'h00001, 20'h08000, 1'b0);
        settle();
        chk("add", 20'(statusWord & 16'h0107), 20'h00104);
        i_cpu.flag(csr_pkg::CSR_OP_SUB, csr_pkg::CSR_SZ_WORD, 20'h00001, 20'h08000, 20'h07FFF, 1'b1);
        settle();
        chk("sub", 20'(statusWord & 16'h0107), 20'h00101);
        i_cpu.flag(csr_pkg::CSR_OP_ADD, csr_pkg::CSR_SZ_BYTE, 20'h000FF, 20'h00001, 20'h00000, 1'b1);
        settle();
        chk("add b", 20'(statusWord & 16'h0107), 20'h00003);
        i_cpu.flag(csr_pkg::CSR_OP_ADD, csr_pkg::CSR_SZ_WORD, 20'h00001, 20'h00001, 20'h00002, 1'b0);
        settle();
        chk("add p", 20'(statusWord & 16'h0107), 20'h00000);
        $display("test flags done");
        i_cpu.wr(csr_pkg::REG_SP, csr_pkg::CSR_SZ_ADDR, 1'b0, 20'h01231, 1'b0);
        settle();
        chk("sp odd", stackTopPtr, 20'h01230);
        i_cpu.push(1'b0);
        settle();
        chk("sp push", stackTopPtr, 20'h0122E);
        i_cpu.wr(csr_pkg::REG_SP, csr_pkg::CSR_SZ_ADDR, 1'b0, 20'h01240, 1'b1);
        settle();
        chk("sp pop", stackTopPtr, 20'h01240);
        i_cpu.push(1'b1);
        settle();
        chk("sp push a", stackTopPtr, 20'h0123C);
        $display("test stack done");
        conclude();
    end

    initial
    begin
        #20000;
        error_cnt++;
        conclude();
    end
endmodule : cpu_status_and_constant_regs_tb_top

// ---- csr_cpu_model.sv ----
`timescale 1ns/1ps
module csr_cpu_model (
    input  wire logic               clk,
    input  wire logic [19:0]        srcData,
    input  wire logic               srcFromConst,
    output csr_pkg::csr_wr_t        wrReq,
    output csr_pkg::csr_flag_t      flagReq,
    output csr_pkg::csr_src_t       srcReq,
    output logic                    spPushEn,
    output logic                    spPopEn,
    output logic                    spAddrWord,
    output logic                    dcoInUse,
    output logic                    lfxtInUse,
    output logic                    irqReq
);
    initial
    begin
        wrReq = '0;
        flagReq = '0;
        srcReq = '0;
        {spPushEn, spPopEn, spAddrWord, dcoInUse, lfxtInUse, irqReq} = 6'h00;
    end

    // status gets 16-bit data only; upper bits would be undefined
    task automatic wr(input logic [3:0] i, input csr_pkg::csr_size_t s, input logic x,
                      input logic [19:0] d, input logic pop);
        @(posedge clk);
        #1;
        wrReq = '{1'b1, i, s, x, (i == csr_pkg::REG_SR) ? (d & 20'h0FFFF) : d};
        spPopEn = pop;
        @(posedge clk);
        #1;
        wrReq.en = 1'b0;
        spPopEn = 1'b0;
    endtask : wr

    task automatic flag(input csr_pkg::csr_op_t o, input csr_pkg::csr_size_t s,
                        input logic [19:0] a, input logic [19:0] b, input logic [19:0] r,
                        input logic c);
        @(posedge clk);
        #1;
        flagReq = '{1'b1, o, s, a, b, r, c};
        @(posedge clk);
        #1;
        flagReq.en = 1'b0;
    endtask : flag

    task automatic rd(input logic [3:0] i, input logic [1:0] m, input csr_pkg::csr_size_t s,
                      output logic [19:0] v, output logic k);
        @(posedge clk);
        #1;
        srcReq = '{i, m, s};
        @(posedge clk);
        #1;
        v = srcData;
        k = srcFromConst;
    endtask : rd

    // address-word pushes step by four, word pushes by two
    task automatic push(input logic a);
        @(posedge clk);
        #1;
        spPushEn = 1'b1;
        spAddrWord = a;
        @(posedge clk);
        #1;
        spPushEn = 1'b0;
        spAddrWord = 1'b0;
    endtask : push

    task automatic env(input logic dco, input logic lfxt, input logic irq);
        @(posedge clk);
        #1;
        {dcoInUse, lfxtInUse, irqReq} = {dco, lfxt, irq};
    endtask : env
endmodule : csr_cpu_model

// ---- csr_pkg.sv ----
// Overview of operation
// RULE1: popping into stack pointer skips post-increment
// RULE2: status word operand only as register word
// RULE3: software must not write 20-bit status values
// RULE4: add overflow on same-sign operands, flipped result
// RULE5: subtract overflow on mixed signs, flipped result
// RULE6: dc generator halts unless digital clock used
// RULE7: second control bit halts oscillator loop control
// RULE8: crystal halts unless its clock is used
// RULE9: core halt bit stops execution
// RULE10: irq gate passes or blocks maskable interrupts
// RULE11: negative flag follows result sign
// RULE12: zero flag set on zero result
// RULE13: carry flag follows carry out
// RULE14: status source modes give 0, 4, 8
// RULE15: third register modes give 0, 1, 2, -1
// RULE16: constant registers are source-only, never written
// RULE17: constants need no extra word or fetch
// RULE18: twelve general registers four to fifteen
// RULE19: byte write clears bits 19:8
// RULE20: word write clears bits 19:16
// RULE21: sign extend fills all upper bits
// RULE22: stack pointer bit zero stays zero
// RULE23: reserved status bits read zero, ignore writes
package csr_pkg;
    localparam int          ADDR_W      = 20;
    localparam logic [3:0]  REG_SP      = 4'h1;
    localparam logic [3:0]  REG_SR      = 4'h2;
    localparam logic [3:0]  REG_CG      = 4'h3;
    localparam int          FLAG_C      = 0;
    localparam int          FLAG_Z      = 1;
    localparam int          FLAG_N      = 2;
    localparam int          FLAG_GIE    = 3;
    localparam int          FLAG_CORE_HALT_BIT = 4;
    localparam int          FLAG_LOW_FREQ_XTAL_HALT = 5;
    localparam int          FLAG_LOOP_CONTROL_HALT   = 6;
    localparam int          FLAG_DC_GENERATOR_HALT   = 7;
    localparam int          FLAG_V      = 8;
    localparam logic [15:0] SR_MASK     = 16'h01FF;
    localparam logic [15:0] SR_RESET    = 16'h0000;
    localparam logic [19:0] REG_RESET   = 20'h00000;
    localparam logic [19:0] CG_ZERO     = 20'h00000;
    localparam logic [19:0] CG_ONE      = 20'h00001;
    localparam logic [19:0] CG_TWO      = 20'h00002;
    localparam logic [19:0] CG_FOUR     = 20'h00004;
    localparam logic [19:0] CG_EIGHT    = 20'h00008;
    localparam logic [19:0] CG_ONES     = 20'hFFFFF;
    localparam logic [19:0] SP_STEP_W   = 20'h00002;
    localparam logic [19:0] SP_STEP_A   = 20'h00004;
    localparam logic [1:0]  MODE_REG    = 2'h0;
    localparam logic [1:0]  MODE_IDX    = 2'h1;
    localparam logic [1:0]  MODE_IND    = 2'h2;
    localparam logic [1:0]  MODE_INC    = 2'h3;

    typedef enum logic [1:0] {
        CSR_SZ_BYTE = 2'h0,
        CSR_SZ_WORD = 2'h1,
        CSR_SZ_ADDR = 2'h2
    } csr_size_t;

    typedef enum logic [1:0] {
        CSR_OP_LOGIC = 2'h0,
        CSR_OP_ADD   = 2'h1,
        CSR_OP_SUB   = 2'h2
    } csr_op_t;

    typedef struct packed {
        logic        en;
        logic [3:0]  idx;
        csr_size_t   size;
        logic        signExt;
        logic [19:0] data;
    } csr_wr_t;

    typedef struct packed {
        logic        en;
        csr_op_t     op;
        csr_size_t   size;
        logic [19:0] srcVal;
        logic [19:0] dstVal;
        logic [19:0] result;
        logic        carry;
    } csr_flag_t;

    typedef struct packed {
        logic [3:0]  idx;
        logic [1:0]  mode;
        csr_size_t   size;
    } csr_src_t;
endpackage : csr_pkg

// ---- csr_reg_file.sv ----
`timescale 1ns/1ps
module csr_reg_file (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire csr_pkg::csr_wr_t    wrReq,
    input  wire csr_pkg::csr_flag_t  flagReq,
    input  wire csr_pkg::csr_src_t   srcReq,
    input  wire logic                spPushEn,
    input  wire logic                spPopEn,
    input  wire logic                spAddrWord,
    input  wire logic                dcoInUse,
    input  wire logic                lfxtInUse,
    input  wire logic                irqReq,
    output logic                     irqTake,
    output logic [19:0]              srcData,
    output logic                     srcFromConst,
    output logic [15:0]              statusWord,
    output logic [19:0]              stackTopPtr,
    output logic                     coreHalt,
    output logic                     dcGenHalt,
    output logic                     loopCtrlHalt,
    output logic                     xtalHalt
);
    logic [19:0] gpReg [0:15];
    logic [15:0] status_reg;
    logic [19:0] srcData_reg;
    logic        srcFromConst_reg;
    logic        coreHalt_reg;
    logic        dcGenHalt_reg;
    logic        loopCtrlHalt_reg;
    logic        xtalHalt_reg;
    logic [19:0] wrValue;
    logic        srWrite;
    logic        gpWrite;
    logic [19:0] spStep;

    function automatic logic [19:0] sizeMask(input csr_pkg::csr_size_t sz);
        unique case (sz)
            csr_pkg::CSR_SZ_BYTE: sizeMask = 20'h000FF;
            csr_pkg::CSR_SZ_WORD: sizeMask = 20'h0FFFF;
            default:              sizeMask = 20'hFFFFF;
        endcase
    endfunction : sizeMask

    function automatic logic signOf(input csr_pkg::csr_size_t sz, input logic [19:0] v);
        unique case (sz)
            csr_pkg::CSR_SZ_BYTE: signOf = v[7];
            csr_pkg::CSR_SZ_WORD: signOf = v[15];
            default:              signOf = v[19];
        endcase
    endfunction : signOf

    // masking covers byte and word clearing; sign extend overrides it
    always_comb
    begin
        if (wrReq.signExt)
            wrValue = {{12{wrReq.data[7]}}, wrReq.data[7:0]}; // RULE21
        else
            wrValue = wrReq.data & sizeMask(wrReq.size); // RULE19 RULE20
    end

    // status only takes word-size register writes; 20-bit writes are never stored
    assign srWrite = wrReq.en && wrReq.idx == csr_pkg::REG_SR
                     && wrReq.size == csr_pkg::CSR_SZ_WORD; // RULE2 RULE3
    // constant register is never a destination
    assign gpWrite = wrReq.en && wrReq.idx != csr_pkg::REG_SR
                     && wrReq.idx != csr_pkg::REG_CG; // RULE16
    assign spStep  = spAddrWord ? csr_pkg::SP_STEP_A : csr_pkg::SP_STEP_W;

    // entries 2 and 3 are written only by reset; their reads are steered elsewhere
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 16; i++)
                gpReg[i] <= csr_pkg::REG_RESET; // RULE18
        end
        else
        begin
            if (gpWrite && wrReq.idx != csr_pkg::REG_SP)
                gpReg[wrReq.idx] <= wrValue; // RULE18
            // an explicit write to the stack pointer beats the pop increment
            if (gpWrite && wrReq.idx == csr_pkg::REG_SP)
                gpReg[csr_pkg::REG_SP] <= {wrValue[19:1], 1'b0}; // RULE1 RULE22
            else if (spPushEn)
                gpReg[csr_pkg::REG_SP] <= (gpReg[csr_pkg::REG_SP] - spStep) & 20'hFFFFE; // RULE22
            else if (spPopEn)
                gpReg[csr_pkg::REG_SP] <= (gpReg[csr_pkg::REG_SP] + spStep) & 20'hFFFFE; // RULE22
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            status_reg <= csr_pkg::SR_RESET;
        else if (srWrite)
            status_reg <= wrReq.data[15:0] & csr_pkg::SR_MASK; // RULE23
        else if (flagReq.en)
        begin
            status_reg[csr_pkg::FLAG_N] <= signOf(flagReq.size, flagReq.result); // RULE11
            status_reg[csr_pkg::FLAG_Z] <=
                (flagReq.result & sizeMask(flagReq.size)) == 20'h00000; // RULE12
            status_reg[csr_pkg::FLAG_C] <= flagReq.carry; // RULE13
            unique case (flagReq.op)
                csr_pkg::CSR_OP_ADD:
                    status_reg[csr_pkg::FLAG_V] <=
                        signOf(flagReq.size, flagReq.srcVal) == signOf(flagReq.size, flagReq.dstVal)
                        && signOf(flagReq.size, flagReq.result)
                           != signOf(flagReq.size, flagReq.dstVal); // RULE4
                csr_pkg::CSR_OP_SUB:
                    status_reg[csr_pkg::FLAG_V] <=
                        signOf(flagReq.size, flagReq.srcVal) != signOf(flagReq.size, flagReq.dstVal)
                        && signOf(flagReq.size, flagReq.result)
                           != signOf(flagReq.size, flagReq.dstVal); // RULE5
                default:
                    status_reg[csr_pkg::FLAG_V] <= 1'b0;
            endcase
        end
    end

    // registered read keeps the data output glitch free at the cost of one cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            srcData_reg      <= csr_pkg::REG_RESET;
            srcFromConst_reg <= 1'b0;
        end
        else if (srcReq.idx == csr_pkg::REG_SR)
        begin
            srcFromConst_reg <= srcReq.mode != csr_pkg::MODE_REG; // RULE17
            unique case (srcReq.mode)
                csr_pkg::MODE_REG: srcData_reg <= {4'h0, status_reg}; // RULE2
                csr_pkg::MODE_IDX: srcData_reg <= csr_pkg::CG_ZERO; // RULE14
                csr_pkg::MODE_IND: srcData_reg <= csr_pkg::CG_FOUR; // RULE14
                csr_pkg::MODE_INC: srcData_reg <= csr_pkg::CG_EIGHT; // RULE14
            endcase
        end
        else if (srcReq.idx == csr_pkg::REG_CG)
        begin
            srcFromConst_reg <= 1'b1; // RULE16 RULE17
            unique case (srcReq.mode)
                csr_pkg::MODE_REG: srcData_reg <= csr_pkg::CG_ZERO; // RULE15
                csr_pkg::MODE_IDX: srcData_reg <= csr_pkg::CG_ONE; // RULE15
                csr_pkg::MODE_IND: srcData_reg <= csr_pkg::CG_TWO; // RULE15
                csr_pkg::MODE_INC: srcData_reg <= csr_pkg::CG_ONES & sizeMask(srcReq.size); // RULE15
            endcase
        end
        else
        begin
            srcFromConst_reg <= 1'b0;
            srcData_reg      <= gpReg[srcReq.idx] & sizeMask(srcReq.size);
        end
    end

    // a clock still in use keeps its source running whatever the bit says
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            coreHalt_reg     <= 1'b0;
            dcGenHalt_reg    <= 1'b0;
            loopCtrlHalt_reg <= 1'b0;
            xtalHalt_reg     <= 1'b0;
        end
        else
        begin
            coreHalt_reg     <= status_reg[csr_pkg::FLAG_CORE_HALT_BIT]; // RULE9
            dcGenHalt_reg    <= status_reg[csr_pkg::FLAG_DC_GENERATOR_HALT] && !dcoInUse; // RULE6
            loopCtrlHalt_reg <= status_reg[csr_pkg::FLAG_LOOP_CONTROL_HALT]; // RULE7
            xtalHalt_reg     <= status_reg[csr_pkg::FLAG_LOW_FREQ_XTAL_HALT] && !lfxtInUse; // RULE8
        end
    end

    assign irqTake      = irqReq && status_reg[csr_pkg::FLAG_GIE]; // RULE10
    assign srcData      = srcData_reg;
    assign srcFromConst = srcFromConst_reg;
    assign statusWord   = status_reg;
    assign stackTopPtr  = gpReg[csr_pkg::REG_SP];
    assign coreHalt     = coreHalt_reg;
    assign dcGenHalt    = dcGenHalt_reg;
    assign loopCtrlHalt = loopCtrlHalt_reg;
    assign xtalHalt     = xtalHalt_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence spPopWrite;
        gpWrite && wrReq.idx == csr_pkg::REG_SP && spPopEn;
    endsequence

    sequence haltWrite;
        srWrite && wrReq.data[csr_pkg::FLAG_CORE_HALT_BIT];
    endsequence

    AST_SP_EVEN: assert property (stackTopPtr[0] == 1'b0) // RULE22
        else $error("stack pointer odd");
    AST_POP_SP: assert property (spPopWrite |=> stackTopPtr == {$past(wrValue[19:1]), 1'b0}) // RULE1
        else $error("pop into stack pointer was incremented");
    AST_BYTE_CLR: assert property (gpWrite && wrReq.size == csr_pkg::CSR_SZ_BYTE
        && !wrReq.signExt && wrReq.idx > 4'h3 |=> gpReg[$past(wrReq.idx)][19:8] == 12'h000) // RULE19
        else $error("byte write left upper bits");
    AST_WORD_CLR: assert property (gpWrite && wrReq.size == csr_pkg::CSR_SZ_WORD
        && !wrReq.signExt && wrReq.idx > 4'h3
        |=> gpReg[$past(wrReq.idx)] == {4'h0, $past(wrReq.data[15:0])}) // RULE20
        else $error("word write wrong");
    AST_SXT: assert property (gpWrite && wrReq.signExt && wrReq.idx > 4'h3
        |=> gpReg[$past(wrReq.idx)][19:8] == {12{$past(wrReq.data[7])}}) // RULE21
        else $error("sign not extended");
    AST_SR_RSVD: assert property (statusWord[15:9] == 7'h00) // RULE23
        else $error("reserved status bits set");
    AST_CG_ONES: assert property (srcReq.idx == csr_pkg::REG_CG && srcReq.mode == csr_pkg::MODE_INC
        && srcReq.size == csr_pkg::CSR_SZ_BYTE |=> srcData == 20'h000FF && srcFromConst) // RULE15
        else $error("minus one constant wrong");
    AST_CG_FOUR: assert property (srcReq.idx == csr_pkg::REG_SR && srcReq.mode == csr_pkg::MODE_IND
        |=> srcData == csr_pkg::CG_FOUR) // RULE14
        else $error("four constant wrong");
    AST_HALT: assert property (haltWrite |-> ##2 coreHalt) // RULE9
        else $error("core did not halt");
    AST_IRQ: assert property (irqReq && !statusWord[csr_pkg::FLAG_GIE] |-> !irqTake) // RULE10
        else $error("interrupt passed closed gate");
    AST_ZERO: assert property (flagReq.en && !srWrite && flagReq.result == 20'h00000
        |=> statusWord[csr_pkg::FLAG_Z]) // RULE12
        else $error("zero flag missing");
    AST_DCGEN: assert property (dcoInUse |=> !dcGenHalt) // RULE6
        else $error("dc generator halted while in use");
endmodule : csr_reg_file
